// ===== logic/channel_word_mem.v
`timescale 1ns/1ps
// --------------------------------------------------------------
// Word store, one write port, registered read port
// --------------------------------------------------------------
module channel_word_mem #(
  parameter AW = 5,
  parameter DW = 32
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: each word is defined by its first write
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== logic/serial_channel_defs.vh
`ifndef SERIAL_CHANNEL_DEFS_VH
`define SERIAL_CHANNEL_DEFS_VH
// --------------------------------------------------------------
// Register map (byte addresses, channel block = 16 bytes)
// --------------------------------------------------------------
`define WSEL_CS 2'h0
`define WSEL_IF0 2'h1
`define WSEL_IF1 2'h2
`define WSEL_IF2 2'h3
`define REG_COMMAND 9'h100
`define REG_DISC 9'h104
`define REG_ELEM 9'h108
`define REG_PACK 9'h10c
`define REG_SCALE_LOW 9'h110
`define REG_SCALE_HIGH 9'h114
// --------------------------------------------------------------
// Command word
// --------------------------------------------------------------
`define CMD_IGNORE 31
`define CMD_OP_STOP 8'h08
`define CMD_OP_START 8'h09
`define CMD_OP_SETUP 8'h0f
`define CMD_OP_XFER 8'h10
// --------------------------------------------------------------
// Status bytes
// --------------------------------------------------------------
`define LS_NOT_READY 7
`define LS_NO_IDENT 6
`define LS_LINK_ERR 5
`define LS_FAR_FAULT 0
`define LF_EXCESS 7
`define LF_FAR_FAULT 6
`define LF_BREAK 5
`define LF_SURPLUS 4
`define LF_LATE 3
`define LF_OVERFLOW 2
`define LF_BAD_TOKEN 1
`define LF_CHECKSUM 0
`define REV_FAR_FAULT 8'd29
// --------------------------------------------------------------
// Element and setting records
// --------------------------------------------------------------
`define REC_ELEMENT 8'ha0
`define REC_SETTING 8'hb0
`define KIND_LAST 8'h07
`define DIR_IN 8'h00
`define DIR_TWO 8'h40
`define DIR_OUT 8'h80
`define SET_JUMPER 8'h00
`define SET_RUNTIME 8'h01
`define PD_LIMIT 8'd96
`define SETTING_RECORDS 4'd2
`define ELEM_FIXED_LAST 5'd13
`define SET_FIXED_LAST 5'd3
`define ZERO_WORD 32'h00000000
`endif

// ===== logic/serial_channel_status.v
`timescale 1ns/1ps
`include "serial_channel_defs.vh"
module serial_channel_status #(
  parameter NUM_CH = 8,
  parameter CH_BITS = 3,
  parameter [7:0] FW_REVISION = 8'd29
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  output wire [31:0] command_word,
  output wire command_pending,
  input wire command_done,
  output wire [NUM_CH*32-1:0] host_cs_words,
  input wire ident_valid,
  input wire [CH_BITS-1:0] ident_ch,
  input wire [31:0] unit_number,
  input wire [31:0] name_chars,
  input wire discovery_supported,
  input wire [15:0] global_table_pointer,
  input wire [15:0] process_table_pointer,
  input wire pd_valid,
  output wire pd_ready,
  input wire [CH_BITS-1:0] pd_ch,
  input wire [1:0] pd_word,
  input wire [31:0] pd_data,
  input wire [CH_BITS-1:0] out_ch,
  input wire [1:0] out_word,
  output wire [31:0] out_data,
  input wire stat_valid,
  input wire [CH_BITS-1:0] stat_ch,
  input wire [7:0] link_state_code,
  input wire link_not_ready_flag,
  input wire missing_identity_flag,
  input wire link_error_flag,
  input wire far_end_fault_flag,
  input wire fault_valid,
  input wire [CH_BITS-1:0] fault_ch,
  input wire excess_error_flag,
  input wire far_fault_seen,
  input wire line_break_flag,
  input wire surplus_char_flag,
  input wire reply_late_flag,
  input wire receive_overflow_flag,
  input wire bad_token_flag,
  input wire checksum_mismatch_flag,
  input wire remote_valid,
  input wire [CH_BITS-1:0] remote_ch,
  input wire [7:0] remote_fault_byte,
  input wire entry_valid,
  input wire [15:0] entry_value,
  input wire rec_valid,
  input wire [7:0] rec_byte
);
  localparam AW = CH_BITS + 2;
  localparam S_IDLE = 2'd0;
  localparam S_FIXED = 2'd1;
  localparam S_STR1 = 2'd2;
  localparam S_STR2 = 2'd3;

  integer i;
  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  reg act_reg;
  reg wr_reg;
  reg [8:0] addr_reg;
  reg [31:0] command_reg;
  reg [31:0] cs_host_reg [0:NUM_CH-1];
  reg [7:0] state_reg [0:NUM_CH-1];
  reg [7:0] link_reg [0:NUM_CH-1];
  reg [7:0] local_reg [0:NUM_CH-1];
  reg [7:0] far_reg [0:NUM_CH-1];
  reg [NUM_CH-1:0] far_ok_reg;
  reg [31:0] reg_rd;
  wire take = hsel && hready && htrans[1];
  wire wr_now = act_reg && wr_reg;
  wire in_chan = (addr_reg[8:AW+2] == 0);
  wire [CH_BITS-1:0] a_ch = addr_reg[AW+1:4];
  wire [1:0] a_w = addr_reg[3:2];
  wire [31:0] mem_q;
  wire [7:0] op = hwdata[15:8];
  wire cmd_take = wr_now && addr_reg == `REG_COMMAND
                  && !hwdata[`CMD_IGNORE];
  wire stop_now = cmd_take && op == `CMD_OP_STOP;
  wire start_now = cmd_take
                   && (op == `CMD_OP_START || op == `CMD_OP_SETUP);
  wire [NUM_CH-1:0] stop_mask = (hwdata[NUM_CH-1:0] == 0)
                                ? {NUM_CH{1'b1}} : hwdata[NUM_CH-1:0];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign command_word = command_reg;
  assign command_pending = command_reg != `ZERO_WORD;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 9'h000;
    end
    else if (hready)
    begin
      act_reg <= take;
      wr_reg <= hwrite;
      addr_reg <= (haddr[31:9] == 0) ? haddr[8:0] : 9'h1fc;
    end
  end

  // Command stays non-zero until the engine reports completion
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      command_reg <= `ZERO_WORD;
    else if (cmd_take)
      command_reg <= hwdata;
    else if (command_done)
      command_reg <= `ZERO_WORD;
  end

  // --------------------------------------------------------------
  // Per channel status
  // --------------------------------------------------------------
  wire [7:0] link_byte = {link_not_ready_flag, missing_identity_flag,
                          link_error_flag, 4'h0,
                          far_end_fault_flag};
  wire [7:0] fault_byte = {excess_error_flag, far_fault_seen,
                           line_break_flag, surplus_char_flag,
                           reply_late_flag, receive_overflow_flag,
                           bad_token_flag,
                           checksum_mismatch_flag};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      far_ok_reg <= {NUM_CH{1'b0}};
      for (i = 0; i < NUM_CH; i = i + 1)
      begin
        cs_host_reg[i] <= `ZERO_WORD;
        state_reg[i] <= 8'h00;
        link_reg[i] <= 8'h00;
        local_reg[i] <= 8'h00;
        far_reg[i] <= 8'h00;
      end
    end
    else
    begin
      for (i = 0; i < NUM_CH; i = i + 1)
      begin
        // Host word is only stored and handed on: mode byte at start,
        // setup requests in setup mode
        if (wr_now && in_chan && a_ch == i && a_w == `WSEL_CS)
          cs_host_reg[i] <= hwdata;
        if (stat_valid && stat_ch == i)
        begin
          state_reg[i] <= link_state_code;
          link_reg[i] <= link_byte;
        end
        // Set wins over a stop in the same cycle
        if (fault_valid && fault_ch == i)
          local_reg[i] <= (stop_now && stop_mask[i] ? 8'h00
                           : local_reg[i]) | fault_byte;
        else if (stop_now && stop_mask[i])
          local_reg[i] <= 8'h00;
        if (remote_valid && remote_ch == i)
        begin
          far_reg[i] <= remote_fault_byte;
          far_ok_reg[i] <= 1'b1;
        end
        else if (ident_valid && ident_ch == i)
          far_ok_reg[i] <= 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : hcs
      assign host_cs_words[g*32+31:g*32] = cs_host_reg[g];
    end
  endgenerate

  // Older firmware leaves the top byte unset until a transfer
  function [7:0] top_byte;
    input [7:0] far;
    input ok;
    begin
      top_byte = (ok || FW_REVISION >= `REV_FAR_FAULT) ? far
                 : 8'h00;
    end
  endfunction

  // --------------------------------------------------------------
  // Incoming words: identification then process data
  // --------------------------------------------------------------
  reg [1:0] id_cnt_reg;
  reg [CH_BITS-1:0] id_ch_reg;
  reg [31:0] id_w0_reg;
  reg [31:0] id_w1_reg;
  reg [31:0] id_w2_reg;
  reg in_we;
  reg [AW-1:0] in_wa;
  reg [31:0] in_wd;
  wire id_busy = id_cnt_reg != 2'd0;

  assign pd_ready = !id_busy && !ident_valid;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      id_cnt_reg <= 2'd0;
      id_ch_reg <= {CH_BITS{1'b0}};
      id_w0_reg <= `ZERO_WORD;
      id_w1_reg <= `ZERO_WORD;
      id_w2_reg <= `ZERO_WORD;
    end
    else if (ident_valid && !id_busy)
    begin
      id_cnt_reg <= 2'd3;
      id_ch_reg <= ident_ch;
      id_w0_reg <= unit_number;
      id_w1_reg <= name_chars;
      id_w2_reg <= discovery_supported
                   ? {global_table_pointer, process_table_pointer}
                   : `ZERO_WORD;
    end
    else if (id_busy)
      id_cnt_reg <= id_cnt_reg - 2'd1;
  end

  always @*
  begin
    in_we = 1'b0;
    in_wa = {id_ch_reg, 2'b00};
    in_wd = id_w0_reg;
    if (id_busy)
    begin
      in_we = 1'b1;
      case (id_cnt_reg)
        2'd3:
        begin
          in_wa = {id_ch_reg, `WSEL_IF0};
          in_wd = id_w0_reg;
        end
        2'd2:
        begin
          in_wa = {id_ch_reg, `WSEL_IF1};
          in_wd = id_w1_reg;
        end
        default:
        begin
          in_wa = {id_ch_reg, `WSEL_IF2};
          in_wd = id_w2_reg;
        end
      endcase
    end
    else if (pd_valid && pd_ready)
    begin
      in_we = 1'b1;
      in_wa = {pd_ch, pd_word + 2'd1};
      in_wd = pd_data;
    end
  end

  channel_word_mem #(.AW(AW), .DW(32)) in_mem (
    .clk(hclk),
    .wr_en(in_we),
    .wr_addr(in_wa),
    .wr_data(in_wd),
    .rd_addr(haddr[AW+1:2]),
    .rd_data(mem_q)
  );

  // Host outgoing words are kept apart from incoming ones
  channel_word_mem #(.AW(AW), .DW(32)) out_mem (
    .clk(hclk),
    .wr_en(wr_now && in_chan && a_w != `WSEL_CS),
    .wr_addr(addr_reg[AW+1:2]),
    .wr_data(hwdata),
    .rd_addr({out_ch, out_word + 2'd1}),
    .rd_data(out_data)
  );

  // --------------------------------------------------------------
  // Process table and record decoding
  // --------------------------------------------------------------
  reg [1:0] ps_reg;
  reg [4:0] idx_reg;
  reg [7:0] rtype_reg;
  reg [7:0] size_reg;
  reg [7:0] kind_reg;
  reg [7:0] dir_reg;
  reg [31:0] low_reg;
  reg [31:0] high_reg;
  reg [15:0] loc_reg;
  reg [7:0] set_kind_reg;
  reg [8:0] in_off_reg;
  reg [8:0] out_off_reg;
  reg [3:0] set_cnt_reg;
  reg [7:0] entry_cnt_reg;
  reg table_end_reg;
  reg bad_rec_reg;
  reg over_reg;
  reg jumper_seen_reg;
  reg runtime_seen_reg;
  wire [4:0] fixed_last = (rtype_reg == `REC_ELEMENT)
                          ? `ELEM_FIXED_LAST : `SET_FIXED_LAST;
  wire goes_in = dir_reg == `DIR_IN || dir_reg == `DIR_TWO;
  wire goes_out = dir_reg == `DIR_OUT || dir_reg == `DIR_TWO;
  wire [8:0] in_sum = in_off_reg + {1'b0, size_reg};
  wire [8:0] out_sum = out_off_reg + {1'b0, size_reg};
  wire rec_end = rec_valid && rec_byte == 8'h00
                 && ((ps_reg == S_STR2)
                 || (ps_reg == S_STR1 && rtype_reg == `REC_SETTING));
  wire dir_ok = dir_reg == `DIR_IN || dir_reg == `DIR_OUT
                || dir_reg == `DIR_TWO;
  wire elem_ok = size_reg != 8'h00 && kind_reg <= `KIND_LAST
                 && dir_ok;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ps_reg <= S_IDLE;
      idx_reg <= 5'd0;
      rtype_reg <= 8'h00;
      size_reg <= 8'h00;
      kind_reg <= 8'h00;
      dir_reg <= 8'h00;
      low_reg <= `ZERO_WORD;
      high_reg <= `ZERO_WORD;
      loc_reg <= 16'h0000;
      set_kind_reg <= 8'h00;
      in_off_reg <= 9'h000;
      out_off_reg <= 9'h000;
      set_cnt_reg <= 4'h0;
      entry_cnt_reg <= 8'h00;
      table_end_reg <= 1'b0;
      bad_rec_reg <= 1'b0;
      over_reg <= 1'b0;
      jumper_seen_reg <= 1'b0;
      runtime_seen_reg <= 1'b0;
    end
    else if (start_now)
    begin
      ps_reg <= S_IDLE;
      in_off_reg <= 9'h000;
      out_off_reg <= 9'h000;
      set_cnt_reg <= 4'h0;
      entry_cnt_reg <= 8'h00;
      table_end_reg <= 1'b0;
      bad_rec_reg <= 1'b0;
      over_reg <= 1'b0;
      jumper_seen_reg <= 1'b0;
      runtime_seen_reg <= 1'b0;
    end
    else
    begin
      if (entry_valid && !table_end_reg)
      begin
        if (entry_value == 16'h0000)
          table_end_reg <= 1'b1;
        else
          entry_cnt_reg <= entry_cnt_reg + 8'h01;
      end
      if (rec_valid)
      begin
        case (ps_reg)
          S_IDLE:
          begin
            rtype_reg <= rec_byte;
            idx_reg <= 5'd1;
            if (rec_byte == `REC_ELEMENT || rec_byte == `REC_SETTING)
              ps_reg <= S_FIXED;
            else
              bad_rec_reg <= 1'b1;
          end
          S_FIXED:
          begin
            idx_reg <= idx_reg + 5'd1;
            if (idx_reg == fixed_last)
              ps_reg <= S_STR1;
            if (rtype_reg == `REC_SETTING)
            begin
              if (idx_reg == 5'd2)
                set_kind_reg <= rec_byte;
            end
            else
            begin
              case (idx_reg)
                5'd1: size_reg <= rec_byte;
                5'd2: kind_reg <= rec_byte;
                5'd3: dir_reg <= rec_byte;
                5'd4, 5'd5, 5'd6, 5'd7:
                  low_reg <= {rec_byte, low_reg[31:8]};
                5'd8, 5'd9, 5'd10, 5'd11:
                  high_reg <= {rec_byte, high_reg[31:8]};
                default: loc_reg <= {rec_byte, loc_reg[15:8]};
              endcase
            end
          end
          S_STR1:
          begin
            if (rec_end)
              ps_reg <= S_IDLE;
            else if (rec_byte == 8'h00)
              ps_reg <= S_STR2;
          end
          default:
          begin
            if (rec_end)
              ps_reg <= S_IDLE;
          end
        endcase
      end
      // Packing walks table order; overflow is flagged, never wrapped
      if (rec_end && rtype_reg == `REC_ELEMENT)
      begin
        if (!elem_ok)
          bad_rec_reg <= 1'b1;
        else
        begin
          if (goes_in)
            in_off_reg <= in_sum;
          if (goes_out)
            out_off_reg <= out_sum;
          if ((goes_in && in_sum > `PD_LIMIT)
              || (goes_out && out_sum > `PD_LIMIT))
            over_reg <= 1'b1;
        end
      end
      if (rec_end && rtype_reg == `REC_SETTING)
      begin
        set_cnt_reg <= set_cnt_reg + 4'h1;
        if (set_kind_reg == `SET_JUMPER)
          jumper_seen_reg <= 1'b1;
        else if (set_kind_reg == `SET_RUNTIME)
          runtime_seen_reg <= 1'b1;
        else
          bad_rec_reg <= 1'b1;
      end
    end
  end

  wire settings_ok = table_end_reg
                     && set_cnt_reg == `SETTING_RECORDS;

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------
  always @*
  begin
    reg_rd = `ZERO_WORD;
    if (in_chan)
      reg_rd = {top_byte(far_reg[a_ch], far_ok_reg[a_ch]),
                state_reg[a_ch], link_reg[a_ch], local_reg[a_ch]};
    else
      case (addr_reg)
        `REG_COMMAND: reg_rd = command_reg;
        `REG_DISC: reg_rd = {16'h0000, entry_cnt_reg, set_cnt_reg,
                             settings_ok, over_reg, bad_rec_reg,
                             table_end_reg};
        `REG_ELEM: reg_rd = {dir_reg, kind_reg, size_reg,
                             6'h00, runtime_seen_reg, jumper_seen_reg};
        `REG_PACK: reg_rd = {loc_reg, out_off_reg[7:0], in_off_reg[7:0]};
        `REG_SCALE_LOW: reg_rd = low_reg;
        `REG_SCALE_HIGH: reg_rd = high_reg;
        default: reg_rd = `ZERO_WORD;
      endcase
  end

  // Status bytes are read live so a status update just before is seen
  assign hrdata = (act_reg && in_chan && a_w != `WSEL_CS) ? mem_q
                  : reg_rd;
endmodule

// ===== tb/engine_model.sv
`timescale 1ns/1ps
// ------------
// Far side
// ------------
module engine_model #(
  parameter LAT = 4,
  parameter [31:0] UNIT = 32'h00000017,
  parameter [31:0] NAME = 32'h64636261,
  parameter [95:0] PD = 96'h0,
  parameter [7:0] FAR = 8'h00
) (
  input wire hclk,
  input wire [31:0] command_word,
  input wire command_pending,
  input wire pd_ready,
  output logic command_done,
  output logic ident_valid,
  output logic [31:0] unit_number,
  output logic [31:0] name_chars,
  output logic pd_valid,
  output logic [1:0] pd_word,
  output logic [31:0] pd_data,
  output logic remote_valid,
  output logic [7:0] remote_fault_byte
);
  logic [7:0] op;
  initial
  begin
    {command_done, ident_valid, pd_valid, remote_valid} = 4'h0;
    pd_word = 2'h0;
    pd_data = 32'h0;
    unit_number = UNIT;
    name_chars = NAME;
    remote_fault_byte = FAR;
    forever
    begin
      @(posedge hclk iff command_pending);
      op = command_word[15:8];
      // Slow on purpose, so the host has to poll
      repeat (LAT) @(posedge hclk);
      if (op == 8'h09 || op == 8'h0f)
      begin
        ident_valid <= 1'b1;
        @(posedge hclk);
        ident_valid <= 1'b0;
        repeat (3) @(posedge hclk);
      end
      if (op == 8'h10)
      begin
        for (int w = 0; w < 3; w++)
        begin
          pd_word <= w[1:0];
          pd_data <= PD[w*32 +: 32];
          pd_valid <= 1'b1;
          @(posedge hclk iff pd_ready);
        end
        pd_valid <= 1'b0;
        // Released data must not look like the last word
        pd_data <= ~pd_data;
        remote_valid <= 1'b1;
        @(posedge hclk);
        remote_valid <= 1'b0;
      end
      command_done <= 1'b1;
      @(posedge hclk);
      command_done <= 1'b0;
    end
  end
endmodule

// ===== tb/status_checker.sv
`timescale 1ns/1ps
// ------------
// Checks
// ------------
module status_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire [31:0] command_word,
  input wire command_pending,
  input wire command_done,
  input wire ident_valid,
  input wire pd_ready
);
  logic wr_q;
  logic rd_q;
  logic [31:0] adr_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data phase tracking, as the slave sees it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 32'h0;
    end
    else
    begin
      wr_q <= hsel && hreadyout && htrans[1] && hwrite;
      rd_q <= hsel && hreadyout && htrans[1] && !hwrite;
      adr_q <= haddr;
    end
  end
  a_zero_wait: assert property (hreadyout)
    else $error("wait state seen");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_unmapped_zero: assert property (
    rd_q && adr_q[31:9] != 23'h0 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmd_store: assert property (
    wr_q && adr_q == 32'h100 && !hwdata[31] && !command_done
    |=> command_word == $past(hwdata))
    else $error("command not stored");
  a_cmd_ignore: assert property (
    wr_q && adr_q == 32'h100 && hwdata[31] && !command_done
    |=> $stable(command_word))
    else $error("ignored command took effect");
  a_done_clears: assert property (
    command_done |=> command_word == 32'h0 && !command_pending)
    else $error("command not cleared");
  a_pending_level: assert property (
    command_pending == (command_word != 32'h0))
    else $error("pending level wrong");
  a_ident_hold: assert property (
    ident_valid |-> !pd_ready ##1 !pd_ready[*2])
    else $error("pd accepted during ident");
  c_done: cover property (command_done);
  c_ident: cover property (ident_valid);
  c_cmd: cover property (wr_q && adr_q == 32'h100);
endmodule

bind serial_channel_status status_checker i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hreadyout,
  .hrdata, .hresp, .command_word, .command_pending, .command_done,
  .ident_valid, .pd_ready
);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ------------
// Bench
// ------------
module tb_top;
  localparam [31:0] UNIT = 32'h00000017;
  localparam [31:0] NAME = 32'h64636261;
  localparam [95:0] PD = 96'h0badf00d_cafe1234_5a5a00ff;
  localparam [7:0] FAR = 8'ha5;
  localparam [95:0] ENTS = 96'h0070_0000_0060_0050_0040_0030;
  // Bits kind first: its scale bytes are junk a consumer must ignore
  localparam [359:0] RECS = {
    136'ha0300100_ffffffff_ffffffff_000000_6100,
    128'ha0400240_11223344_55667788_3412_0000,
    48'hb0000000_6100,
    48'hb0010100_6200};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, command_word;
  logic [31:0] out_data, unit_number, name_chars, pd_data, rd;
  logic [1:0] htrans = 2'h0, out_word = 2'h0, pd_word;
  logic [2:0] hsize = 3'h2, ch = 3'h1;
  logic hready, hresp, command_pending, command_done, ident_valid;
  logic pd_valid, pd_ready, remote_valid, stat_valid = 1'b0;
  logic fault_valid = 1'b0, discovery_supported = 1'b1;
  logic entry_valid = 1'b0, rec_valid = 1'b0;
  logic [15:0] ent = 16'h0000;
  logic [7:0] rb = 8'h00;
  logic [15:0] gtp = 16'h1234, ptp = 16'h0400;
  logic [7:0] remote_fault_byte, lsc = 8'h00, ls = 8'h00, lf = 8'h00;
  logic [255:0] host_cs_words;
  int num_errors = 0, checked = 0;
  always #2.5 hclk = ~hclk;
  serial_channel_status #(.FW_REVISION(8'd29)) i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hrdata, .hresp, .command_word,
    .command_pending, .command_done, .host_cs_words, .ident_valid,
    .ident_ch(ch), .unit_number, .name_chars, .discovery_supported,
    .global_table_pointer(gtp), .process_table_pointer(ptp), .pd_valid,
    .pd_ready, .pd_ch(ch), .pd_word, .pd_data, .out_ch(ch), .out_word,
    .out_data, .stat_valid, .stat_ch(ch), .link_state_code(lsc),
    .link_not_ready_flag(ls[7]), .missing_identity_flag(ls[6]),
    .link_error_flag(ls[5]), .far_end_fault_flag(ls[0]), .fault_valid,
    .fault_ch(ch), .excess_error_flag(lf[7]), .far_fault_seen(lf[6]),
    .line_break_flag(lf[5]), .surplus_char_flag(lf[4]),
    .reply_late_flag(lf[3]), .receive_overflow_flag(lf[2]),
    .bad_token_flag(lf[1]), .checksum_mismatch_flag(lf[0]),
    .remote_valid, .remote_ch(ch), .remote_fault_byte,
    .entry_valid, .entry_value(ent), .rec_valid, .rec_byte(rb)
  );
  engine_model #(.UNIT(UNIT), .NAME(NAME), .PD(PD), .FAR(FAR)) i_eng (
    .hclk, .command_word, .command_pending, .pd_ready, .command_done,
    .ident_valid, .unit_number, .name_chars, .pd_valid, .pd_word,
    .pd_data, .remote_valid, .remote_fault_byte
  );
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rdy;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge hclk);
      if (hready === 1'b1)
        return;
    end
    num_errors++;
    test_done();
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  // Poll the command register; a hang ends the run
  task automatic wait_idle;
    for (int n = 0; n < 64; n++)
    begin
      bus(1'b0, 32'h100, 32'h0);
      if (rd === 32'h0)
        return;
    end
    num_errors++;
    test_done();
  endtask
  task automatic t_reset;
    bus(1'b0, 32'h10, 32'h0);
    chk("cs reset", rd, 32'h0);
    bus(1'b1, 32'h10, 32'h5a000000);
    bus(1'b0, 32'h10, 32'h0);
    chk("cs inert", rd, 32'h0);
    chk("mode", host_cs_words[63:32], 32'h5a000000);
    bus(1'b1, 32'h204, 32'hffffffff);
    bus(1'b0, 32'h204, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_start;
    for (int k = 0; k < 2; k++)
    begin
      discovery_supported <= (k == 0);
      bus(1'b1, 32'h100, (k == 0) ? 32'h0902 : 32'h0f02);
      wait_idle();
      bus(1'b0, 32'h14, 32'h0);
      chk("unit", rd, UNIT);
      bus(1'b0, 32'h18, 32'h0);
      chk("name", rd, NAME);
      bus(1'b0, 32'h1c, 32'h0);
      chk("pointers", rd, (k == 0) ? {gtp, ptp} : 32'h0);
    end
  endtask
  task automatic t_status;
    lsc <= 8'h3c;
    ls <= 8'ha1;
    stat_valid <= 1'b1;
    @(posedge hclk);
    stat_valid <= 1'b0;
    // Walk the sticky flags one by one
    for (int b = 0; b < 8; b++)
    begin
      lf <= 8'h01 << b;
      fault_valid <= 1'b1;
      @(posedge hclk);
      fault_valid <= 1'b0;
      lf <= 8'h00;
      bus(1'b0, 32'h10, 32'h0);
      chk("status", rd, {16'h003c, 8'ha1, 8'hff >> (7 - b)});
    end
    bus(1'b1, 32'h100, 32'h0802);
    wait_idle();
    bus(1'b0, 32'h10, 32'h0);
    chk("after stop", {24'h0, rd[7:0]}, 32'h0);
  endtask
  task automatic t_xfer;
    for (int w = 0; w < 3; w++)
      bus(1'b1, 32'h14 + 4 * w, ~PD[w*32 +: 32]);
    for (int w = 0; w < 3; w++)
    begin
      out_word <= w[1:0];
      repeat (2) @(posedge hclk);
      chk("outgoing", out_data, ~PD[w*32 +: 32]);
    end
    bus(1'b1, 32'h100, 32'h80001002);
    bus(1'b0, 32'h100, 32'h0);
    chk("ignored", rd, 32'h0);
    bus(1'b1, 32'h100, 32'h1002);
    wait_idle();
    for (int w = 0; w < 3; w++)
    begin
      bus(1'b0, 32'h14 + 4 * w, 32'h0);
      chk("incoming", rd, PD[w*32 +: 32]);
    end
    bus(1'b0, 32'h10, 32'h0);
    chk("far faults", {rd[31:24], 24'h0}, {FAR, 24'h0});
  endtask
  // Entry after the sentinel must not be counted
  task automatic t_disc;
    for (int i = 0; i < 6; i++)
    begin
      entry_valid <= 1'b1;
      ent <= ENTS[i*16 +: 16];
      @(posedge hclk);
    end
    entry_valid <= 1'b0;
    for (int i = 44; i >= 0; i--)
    begin
      rec_valid <= 1'b1;
      rb <= RECS[i*8 +: 8];
      @(posedge hclk);
    end
    rec_valid <= 1'b0;
    bus(1'b0, 32'h104, 32'h0);
    chk("discovery", rd, 32'h0000042d);
    bus(1'b0, 32'h108, 32'h0);
    chk("element", rd, 32'h40024003);
    bus(1'b0, 32'h10c, 32'h0);
    chk("packing", rd, 32'h12344070);
    bus(1'b0, 32'h110, 32'h0);
    chk("scale low", rd, 32'h44332211);
    bus(1'b0, 32'h114, 32'h0);
    chk("scale high", rd, 32'h88776655);
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_start();
    t_status();
    t_xfer();
    t_disc();
    test_done();
  end
endmodule
